/* File: logic/sfdp_caps_map.svh */
// named constants: instruction codes, table word fields, bit and byte counts of the serial frame
`ifndef SFDP_CAPS_MAP_SVH
`define SFDP_CAPS_MAP_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_VOL_WRITE_ENABLE 8'h50
`define OP_WRITE_STATUS 8'h01
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_READ_SFDP 8'h5A

`define ENTER_4B_FIELD 8'h80
`define EXIT_4B_FIELD 10'h300
`define SOFT_RESET_FIELD 6'h30
`define RFU_BIT7 1'h1
`define SR1_WE_FIELD 7'h68

`define CAPS_WORD_BASE 24'h000068
`define CAPS_WORD_LAST 24'h00006B
`define UNMAPPED_BYTE 8'hFF
// pins at rest {sclk, cs_n, io}: clock low, select high, lanes low
`define PINS_IDLE 6'h10

`define BITS_PER_BYTE 4'h8
`define ADDR_BYTES 3'h3
`define OPCODE_BYTES 3'h1
`define WRSR_BYTES 3'h2
`define WEL_BIT 1
`define SR1_WRITABLE 8'hFC
`define SR1_BUSY_CLEAR 1'h0

`endif

/* File: logic/sfdp_caps_pkg.sv */
// types shared by the serial front end, its assertions and the bench
package sfdp_caps_pkg;

  typedef enum logic [1:0] {
    LANES_1 = 2'b00,
    LANES_2 = 2'b01,
    LANES_4 = 2'b10
  } lanes_t;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b011,
    ST_WRSR = 3'b100,
    ST_IGNORE = 3'b101
  } rx_state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } pins_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } io_drive_t;

endpackage

/* File: logic/sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // only the second stage reads the first
  always_ff @(posedge clock) begin
    // reset to the pins' rest level, else a false edge follows reset
    if (rst) begin
      meta_q <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: logic/flash_cmd.sv */
// serial flash instruction front end: parameter word 68h-6Bh, soft reset, status write enables
`timescale 1ns/100ps
`default_nettype none
`include "sfdp_caps_map.svh"

module flash_cmd
  import sfdp_caps_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire lanes_t lanes,
  input wire logic [7:0] nv_sr1,
  output logic [7:0] sr1,
  output logic nv_wr_stb,
  output logic [7:0] nv_wr_data,
  output logic soft_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  pins_t pins_raw;
  pins_t pins_s;
  logic sclk_prev_q;
  logic cs_n_prev_q;
  logic sclk_rise;
  logic cs_rise;
  logic frame_on;

  assign pins_raw = '{sclk: sclk_pin, cs_n: cs_n_pin, io: io_in};

  sync2 #(.W($bits(pins_t)), .INIT(`PINS_IDLE)) sync2_i (
    .clock(clock),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= pins_s.sclk;
      cs_n_prev_q <= pins_s.cs_n;
    end
  end

  // edges seen a few clocks late; serial clock must stay well below the 20 MHz system rate
  assign sclk_rise = pins_s.sclk & ~sclk_prev_q & ~pins_s.cs_n;
  assign cs_rise = pins_s.cs_n & ~cs_n_prev_q;
  assign frame_on = ~pins_s.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // parameter word and byte lookup
  localparam logic [31:0] CAPS_WORD = {`ENTER_4B_FIELD,
                                       `EXIT_4B_FIELD,
                                       `SOFT_RESET_FIELD, `RFU_BIT7, `SR1_WE_FIELD};

  function automatic logic [7:0] table_byte(input logic [23:0] a);
    logic [7:0] b;
    b = `UNMAPPED_BYTE;
    if (a >= `CAPS_WORD_BASE && a <= `CAPS_WORD_LAST) begin
      b = CAPS_WORD[8*a[1:0] +: 8];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive shifter, shared by all lane widths
  rx_state_t state_q;
  logic [7:0] sh_q;
  logic [7:0] sh_n;
  logic [3:0] step;
  logic [3:0] bitcnt_q;
  logic [2:0] bytecnt_q;
  logic [7:0] opcode_q;
  logic [7:0] wr_byte_q;
  logic [23:0] addr_q;
  logic [7:0] tx_q;
  logic byte_done;

  always_comb begin
    case (lanes)
      LANES_2: begin
        sh_n = {sh_q[5:0], pins_s.io[1:0]};
        step = 4'h2;
      end
      LANES_4: begin
        sh_n = {sh_q[3:0], pins_s.io};
        step = 4'h4;
      end
      default: begin
        sh_n = {sh_q[6:0], pins_s.io[0]};
        step = 4'h1;
      end
    endcase
  end

  assign byte_done = sclk_rise && (bitcnt_q + step == `BITS_PER_BYTE);

  always_ff @(posedge clock) begin
    if (rst || !frame_on) begin
      bitcnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else if (sclk_rise) begin
      bitcnt_q <= byte_done ? 4'h0 : bitcnt_q + step;
      sh_q <= sh_n;
    end
  end

  // byte counter saturates; only small counts matter for decoding
  always_ff @(posedge clock) begin
    if (rst || cs_rise) begin
      bytecnt_q <= 3'h0;
    end else if (byte_done && bytecnt_q != 3'h7) begin
      bytecnt_q <= bytecnt_q + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !frame_on) begin
      state_q <= ST_CMD;
    end else if (byte_done) begin
      case (state_q)
        ST_CMD: begin
          if (sh_n == `OP_READ_SFDP) begin
            state_q <= ST_ADDR;
          end else if (sh_n == `OP_WRITE_STATUS) begin
            state_q <= ST_WRSR;
          end else begin
            state_q <= ST_IGNORE;
          end
        end
        ST_ADDR: begin
          if (bytecnt_q == `ADDR_BYTES) begin
            state_q <= ST_DUMMY;
          end
        end
        ST_DUMMY: state_q <= ST_DATA;
        ST_WRSR: state_q <= ST_IGNORE;
        default: state_q <= state_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      opcode_q <= 8'h00;
      wr_byte_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (byte_done) begin
      if (state_q == ST_CMD) begin
        opcode_q <= sh_n;
      end
      if (state_q == ST_ADDR) begin
        addr_q <= {addr_q[15:0], sh_n};
      end
      if (state_q == ST_WRSR) begin
        wr_byte_q <= sh_n;
      end
      if (state_q == ST_DATA) begin
        addr_q <= addr_q + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: shifts after the host has sampled the rising edge
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (byte_done && state_q == ST_DUMMY) begin
      tx_q <= table_byte(addr_q);
    end else if (byte_done && state_q == ST_DATA) begin
      tx_q <= table_byte(addr_q + 24'h000001);
    end else if (sclk_rise && state_q == ST_DATA) begin
      tx_q <= tx_q << step;
    end
  end

  io_drive_t drive_d;
  io_drive_t drive_q;

  always_comb begin
    drive_d = '{out: 4'h0, oe: 4'h0};
    if (frame_on && state_q == ST_DATA) begin
      case (lanes)
        LANES_2: drive_d = '{out: {2'b00, tx_q[7:6]}, oe: 4'h3};
        LANES_4: drive_d = '{out: tx_q[7:4], oe: 4'hF};
        default: drive_d = '{out: {2'b00, tx_q[7], 1'b0}, oe: 4'h2};
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      drive_q <= '{out: 4'h0, oe: 4'h0};
    end else begin
      drive_q <= drive_d;
    end
  end

  assign io_out = drive_q.out;
  assign io_oe = drive_q.oe;

  ////////////////////////////////////////////////////////////////////////////
  // instruction execution at chip-select release
  logic whole_bytes;
  logic one_byte_op;
  logic do_soft_reset;
  logic wel_q;
  logic vol_sel_q;
  logic reset_en_q;
  logic [7:0] sr1_q;

  // a frame with a partial byte executes nothing
  assign whole_bytes = cs_rise && bitcnt_q == 4'h0;
  assign one_byte_op = whole_bytes && bytecnt_q == `OPCODE_BYTES;
  assign do_soft_reset = one_byte_op && opcode_q == `OP_RESET && reset_en_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_en_q <= 1'b0;
    end else if (one_byte_op && opcode_q == `OP_RESET_ENABLE) begin
      reset_en_q <= 1'b1;
    end else if (whole_bytes && bytecnt_q != 3'h0) begin
      reset_en_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || do_soft_reset) begin
      wel_q <= 1'b0;
      vol_sel_q <= 1'b0;
    end else if (one_byte_op && opcode_q == `OP_WRITE_ENABLE) begin
      wel_q <= 1'b1;
      vol_sel_q <= 1'b0;
    end else if (one_byte_op && opcode_q == `OP_VOL_WRITE_ENABLE) begin
      wel_q <= 1'b1;
      vol_sel_q <= 1'b1;
    end else if (whole_bytes && bytecnt_q == `WRSR_BYTES && opcode_q == `OP_WRITE_STATUS) begin
      wel_q <= 1'b0;
      vol_sel_q <= 1'b0;
    end
  end

  // sync reset doubles as power-up, so the stored copy is loaded here
  always_ff @(posedge clock) begin
    if (rst || do_soft_reset) begin
      sr1_q <= nv_sr1 & `SR1_WRITABLE;
    end else if (whole_bytes && bytecnt_q == `WRSR_BYTES && opcode_q == `OP_WRITE_STATUS
                 && wel_q) begin
      sr1_q <= wr_byte_q & `SR1_WRITABLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nv_wr_stb <= 1'b0;
      nv_wr_data <= 8'h00;
      soft_reset <= 1'b0;
    end else begin
      nv_wr_stb <= whole_bytes && bytecnt_q == `WRSR_BYTES && opcode_q == `OP_WRITE_STATUS
                   && wel_q && !vol_sel_q;
      if (whole_bytes && bytecnt_q == `WRSR_BYTES && opcode_q == `OP_WRITE_STATUS) begin
        nv_wr_data <= wr_byte_q & `SR1_WRITABLE;
      end
      soft_reset <= do_soft_reset;
    end
  end

  always_comb begin
    sr1 = sr1_q;
    sr1[`WEL_BIT] = wel_q;
    sr1[0] = `SR1_BUSY_CLEAR;
  end

endmodule

`default_nettype wire

/* File: logic/sfdp_caps_pkg_unused_guard.sv */
// intentionally empty compilation unit kept out; no content
`default_nettype none
`default_nettype wire

/* File: tb/flash_cmd_asserts.sv */
// port assertions for the flash instruction front end
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_asserts
  import sfdp_caps_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire lanes_t lanes,
  input wire logic [7:0] nv_sr1,
  input wire logic [7:0] sr1,
  input wire logic nv_wr_stb,
  input wire logic [7:0] nv_wr_data,
  input wire logic soft_reset
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_SR1_RELOAD: assert property (soft_reset |-> ##[0:2] (sr1 == (nv_sr1 & 8'hFC)))
    else $error("sr1 not reloaded on soft reset");
  AST_RST_PULSE: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  AST_RST_AFTER_CS: assert property (soft_reset |-> $past(cs_n_pin, 2))
    else $error("soft reset inside a frame");
  AST_NV_DATA: assert property (nv_wr_stb |-> ##[0:1] (sr1[7:2] == nv_wr_data[7:2]))
    else $error("nonvolatile write data differs from sr1");
  AST_STB_PULSE: assert property (nv_wr_stb |=> !nv_wr_stb)
    else $error("nonvolatile strobe longer than one cycle");
  AST_BUSY_ZERO: assert property (sr1[0] == 1'b0)
    else $error("busy bit set");
  // oe drops about 3 clocks after select rises, so 8 idle cycles leave margin
  AST_IDLE_QUIET: assert property (cs_n_pin [*8] |->
    io_oe == 4'h0 && !nv_wr_stb && $stable(sr1))
    else $error("activity while deselected");
  AST_OE_LANES: assert property (|io_oe |->
    io_oe == (lanes == LANES_4 ? 4'hF : (lanes == LANES_2 ? 4'h3 : 4'h2)))
    else $error("output enables do not match lane width");
endmodule
bind flash_cmd flash_cmd_asserts flash_cmd_asserts_i (.clock(clock), .rst(rst),
  .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .lanes(lanes), .nv_sr1(nv_sr1), .sr1(sr1), .nv_wr_stb(nv_wr_stb), .nv_wr_data(nv_wr_data),
  .soft_reset(soft_reset));
`default_nettype wire

/* File: tb/spi_host_model.sv */
// serial host model that frames instructions onto the flash pins
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic clock,
  input wire logic [3:0] io_out,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'h5;
  end
  ////////////////////////////////////////
  // half period of 6 clocks: the front end sees edges one clock apart but drives read data about 4 clocks after a rise
  task automatic xfer(input int l, input logic [63:0] tx, input int nb, input int nr,
                      output logic [31:0] rx);
    logic [7:0] sh;
    int ns;
    ns = 8 * nb / l;
    rx = '0;
    @(negedge clock);
    cs_n = 1'b0;
    for (int s = 0; s < ns + 8 * nr / l; s++) begin
      if (s < ns && s % (8 / l) == 0) sh = tx[63 - 8 * (s * l / 8) -: 8];
      if (s < ns) begin
        io = 4'(sh[7:4] >> (4 - l));
        sh = sh << l;
      end else begin
        io = ~io;
      end
      repeat (6) @(negedge clock);
      if (s >= ns) rx = (rx << l) | (l == 1 ? 32'(io_out[1]) : 32'(io_out) & ((32'd1 << l) - 1));
      sclk = 1'b1;
      repeat (6) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (2) @(negedge clock);
    cs_n = 1'b1;
    io = ~io;
    repeat (12) @(negedge clock);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_sfdp_reset_and_status_write_caps.sv */
// self-checking bench for the flash instruction front end
`timescale 1ns/100ps
`default_nettype none
module test_sfdp_reset_and_status_write_caps;
  import sfdp_caps_pkg::*;
  logic clock, rst, sclk, cs_n, nv_wr_stb, soft_reset;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] nv_sr1, sr1, nv_wr_data, d;
  lanes_t lanes;
  logic [31:0] rnd, rx, w;
  logic [7:0] wr_q[$], rs_q[$];
  int miscompares = 0;
  int samples_checked = 0;
  flash_cmd flash_cmd_i (.clock(clock), .rst(rst), .sclk_pin(sclk), .cs_n_pin(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .lanes(lanes), .nv_sr1(nv_sr1), .sr1(sr1),
    .nv_wr_stb(nv_wr_stb), .nv_wr_data(nv_wr_data), .soft_reset(soft_reset));
  spi_host_model spi_host_model_i (.clock(clock), .io_out(io_out), .sclk(sclk), .cs_n(cs_n),
    .io(io_in));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic op(input int l, input logic [63:0] tx, input int nb);
    spi_host_model_i.xfer(l, tx, nb, 0, rx);
  endtask
  task automatic rd(input int l, input logic [7:0] a, input logic [31:0] exp);
    spi_host_model_i.xfer(l, {8'h5A, 16'h0, a, 8'hFF, 24'h0}, 5, 4, rx);
    check("table_bytes", rx, exp);
  endtask
  ////////////////////////////////////////
  // the strobe and reload monitors pop the oldest note; an unexpected pulse meets x and fails
  always @(negedge clock) begin
    if (nv_wr_stb === 1'b1) begin
      check("nv_wr_data", nv_wr_data, wr_q.size() ? wr_q.pop_front() : 'x);
    end
  end
  always @(negedge clock) begin
    if (io_oe !== 4'h0) begin
      check("io_oe", io_oe, lanes == LANES_4 ? 4'hF : (lanes == LANES_2 ? 4'h3 : 4'h2));
    end
  end
  always @(negedge clock) begin
    if (soft_reset === 1'b1) begin
      repeat (3) @(negedge clock);
      check("sr1_reload", sr1, rs_q.size() ? rs_q.pop_front() : 'x);
    end
  end
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    finish_test();
  end
  initial begin
    rnd = 32'h914BC1E8;
    rst = 1'b1;
    lanes = LANES_1;
    nv_sr1 = rnd[7:0];
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    check("sr1_powerup", sr1, nv_sr1 & 8'hFC);
    w = {8'h80, 10'h300, 6'h30, 1'h1, 7'h68};
    rd(1, 8'h68, {w[7:0], w[15:8], w[23:16], w[31:24]});
    rd(1, 8'h6A, {w[23:16], w[31:24], 16'hFFFF});
    // m: 0 no enable, 1 nonvolatile enable, 2 volatile enable
    for (int m = 0; m < 3; m++) begin
      rnd = lfsr(rnd);
      d = rnd[7:0];
      w = {24'h0, sr1};
      if (m > 0) op(1, {m == 1 ? 8'h06 : 8'h50, 56'h0}, 1);
      if (m > 0) check("wel", sr1[1], 1'b1);
      if (m == 1) wr_q.push_back(d & 8'hFC);
      op(1, {8'h01, d, 48'h0}, 2);
      check("sr1_write", sr1, m > 0 ? d & 8'hFC : w[7:0]);
      if (m == 1) nv_sr1 = d & 8'hFC;
    end
    for (int l = 1; l <= 4; l = l * 2) begin
      lanes = l == 4 ? LANES_4 : (l == 2 ? LANES_2 : LANES_1);
      rd(l, 8'h68, 32'hE830C080);
      rnd = lfsr(rnd);
      nv_sr1 = rnd[7:0];
      if (l == 4) op(4, 64'hFFFFFFFF_00000000, 4);
      op(l, {8'h50, 56'h0}, 1);
      op(l, {8'h66, 56'h0}, 1);
      rs_q.push_back(nv_sr1 & 8'hFC);
      op(l, {8'h99, 56'h0}, 1);
    end
    lanes = LANES_1;
    op(1, {8'h66, 56'h0}, 1);
    op(1, {8'h06, 56'h0}, 1);
    op(1, {8'h99, 56'h0}, 1);
    op(1, {8'h99, 56'h0}, 1);
    check("pending", wr_q.size() + rs_q.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
